// ==== src/lpcpg_pkg.sv ====
// Package of constants and types for the auto-increment page load block.
package lpcpg_pkg;

  // ----------------------------------------------------------------------
  // Frame fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] START_CODE      = 4'hE;
  localparam int         ADDR_NIBBLES    = 7;
  localparam int         PAGE_BYTES      = 128;
  localparam int         PAGE_LSB        = 7;
  localparam int         PAGE_MSB        = 20;
  localparam int         BYTE_IDX_W      = 7;
  localparam int         PAGE_ADDR_W     = PAGE_MSB - PAGE_LSB + 1;

  // ----------------------------------------------------------------------
  // Buffer and programming timing
  // ----------------------------------------------------------------------
  localparam int         FIFO_DEPTH      = 4;
  localparam int         PROG_TIME_NS    = 7000;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEL   = 3'b001,
    ST_ADDR  = 3'b011,
    ST_SIZE  = 3'b010,
    ST_DATA  = 3'b110,
    ST_DRAIN = 3'b111,
    ST_DONE  = 3'b101
  } lpcpg_state_type;

  typedef struct packed {
    logic [PAGE_ADDR_W-1:0] page;
    logic [BYTE_IDX_W-1:0]  index;
    logic [7:0]             data;
  } lpcpg_write_type;

endpackage : lpcpg_pkg

// ==== src/lpcpg_fifo.sv ====
// Small FIFO between the nibble assembler and the array writer.
`timescale 1ns/1ns
module lpcpg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign in_ready_out  = count_ff < (AW+1)'(DEPTH);
  assign out_valid_out = count_ff != '0;
  assign out_data_out  = mem_ff[rd_ptr_ff];

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : lpcpg_fifo

// ==== src/lpcpg_writer.sv ====
// Array writer: takes buffered bytes and spends the programming time per page.
`timescale 1ns/1ns
module lpcpg_writer #(
  parameter int PROG_CYCLES = lpcpg_pkg::PROG_CYCLES
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    in_valid_in,
  output logic                         in_ready_out,
  input  wire lpcpg_pkg::lpcpg_write_type in_word_in,
  input  wire logic                    commit_in,
  output logic                         busy_out,
  output lpcpg_pkg::lpcpg_write_type   last_word_out,
  output logic                         word_strobe_out
);

  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_ff;
  logic                             drain_ff;

  // ----------------------------------------------------------------------
  // Byte sink and page programming timer
  // ----------------------------------------------------------------------
  assign in_ready_out = !drain_ff;
  assign busy_out     = drain_ff;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prog_cnt_ff     <= '0;
      drain_ff        <= 1'b0;
      last_word_out   <= '0;
      word_strobe_out <= 1'b0;
    end else begin
      word_strobe_out <= in_valid_in && !drain_ff;
      if (in_valid_in && !drain_ff) begin
        last_word_out <= in_word_in;
      end
      if (commit_in && !drain_ff) begin
        drain_ff    <= 1'b1;
        prog_cnt_ff <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES);
      end else if (drain_ff) begin
        if (prog_cnt_ff <= 1) begin
          drain_ff <= 1'b0;
        end
        prog_cnt_ff <= prog_cnt_ff - 1'b1;
      end
    end
  end

endmodule : lpcpg_writer

// ==== src/lpcpg_top.sv ====
// Auto-increment page load sequencer of a low-pin-count flash device.
// ----------------------------------------------------------------------
// Overview of operation
// - One address transfer per page; byte index increments internally.
// - Lowest seven address bits ignored; load starts at page byte zero.
// - Ready/busy goes low when buffer is full, high when it drains.
// - After last byte ready/busy stays low until programming ends.
// - Data taken only while strobe low and ready high, up to byte 127.
// - Strobe released early programs bytes received and ends the command.
// - A byte with only one nibble received is discarded.
// - Software block locks are bypassed while the mode is active.
// - Supervoltage lost mid-page leaves page contents undefined.
// - Start code 1110 with frame low; last start before frame high counts.
// - Select nibble must equal the strap pins for the device to respond.
// - Seven address nibbles follow, most significant first.
// - Only address bits 20 down to 7 are used.
// - Size field is ignored.
// - Data bytes arrive low nibble first, byte 0 to byte 127.
// ----------------------------------------------------------------------
`timescale 1ns/1ns
module lpcpg_top #(
  parameter int PROG_CYCLES = lpcpg_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH  = lpcpg_pkg::FIFO_DEPTH
) (
  input  wire logic                              sys_clk_in,
  input  wire logic                              rst_in,
  input  wire logic                              frame_n_in,
  input  wire logic [3:0]                        lad_in,
  input  wire logic                              supervoltage_in,
  input  wire logic                              load_strobe_n_in,
  input  wire logic [3:0]                        strap_select_pins_in,
  output logic                                   ready_busy_n_out,
  output logic                                   lock_bypass_out,
  output logic                                   write_valid_out,
  output lpcpg_pkg::lpcpg_write_type             write_word_out,
  output logic                                   page_done_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  lpcpg_pkg::lpcpg_state_type            state_ff;
  lpcpg_pkg::lpcpg_state_type            nxt_state;
  logic [2:0]                            addr_cnt_ff;
  wire logic [lpcpg_pkg::ADDR_NIBBLES-1:0][3:0] addr_nib;
  logic [27:0]                           addr_word;
  logic [lpcpg_pkg::PAGE_ADDR_W-1:0]     page_ff;
  logic [lpcpg_pkg::BYTE_IDX_W:0]        byte_cnt_ff;
  logic [3:0]                            low_nib_ff;
  logic                                  half_ff;
  logic                                  commit_ff;
  logic                                  ready_ff;
  logic                                  bypass_ff;
  logic                                  done_ff;

  logic                                  start_seen;
  logic                                  in_addr;
  logic                                  in_data;
  logic                                  enter_drain;
  logic                                  commit_go;
  logic                                  nxt_ready;
  logic                                  nib_take;
  logic                                  byte_push;
  logic                                  page_full;
  logic                                  early_end;
  logic                                  fifo_in_ready;
  logic                                  fifo_out_valid;
  logic                                  wr_in_ready;
  logic                                  wr_busy;
  logic                                  wr_strobe;
  lpcpg_pkg::lpcpg_write_type            push_word;
  lpcpg_pkg::lpcpg_write_type            fifo_word;
  lpcpg_pkg::lpcpg_write_type            wr_last;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // True when the byte counter holds the given count.
  function automatic logic count_at(input logic [lpcpg_pkg::BYTE_IDX_W:0] cnt, input int value);
    return cnt == (lpcpg_pkg::BYTE_IDX_W+1)'(value);
  endfunction : count_at

  assign in_addr     = state_ff == lpcpg_pkg::ST_ADDR;
  assign in_data     = state_ff == lpcpg_pkg::ST_DATA;
  assign start_seen  = !frame_n_in && lad_in == lpcpg_pkg::START_CODE && supervoltage_in;
  assign page_full   = count_at(byte_cnt_ff, lpcpg_pkg::PAGE_BYTES);
  // Nibbles count only with the strobe low, the device ready and the page not full.
  assign nib_take    = in_data && !load_strobe_n_in && ready_ff && !page_full;
  assign byte_push   = nib_take && half_ff;
  assign early_end   = in_data && load_strobe_n_in;
  assign enter_drain = in_data && nxt_state == lpcpg_pkg::ST_DRAIN;
  // The commit is handed to the writer only once the buffer has run empty.
  assign commit_go   = state_ff == lpcpg_pkg::ST_DRAIN && !fifo_out_valid && commit_ff;
  assign push_word  = '{page:  page_ff,
                        index: byte_cnt_ff[lpcpg_pkg::BYTE_IDX_W-1:0],
                        data:  {lad_in, low_nib_ff}};

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lpcpg_pkg::ST_IDLE: begin
        if (start_seen) begin
          nxt_state = lpcpg_pkg::ST_SEL;
        end
      end
      lpcpg_pkg::ST_SEL: begin
        if (start_seen) begin
          nxt_state = lpcpg_pkg::ST_SEL;
        end else if (lad_in == strap_select_pins_in) begin
          nxt_state = lpcpg_pkg::ST_ADDR;
        end else begin
          nxt_state = lpcpg_pkg::ST_IDLE;
        end
      end
      lpcpg_pkg::ST_ADDR: begin
        if (addr_cnt_ff == 3'(lpcpg_pkg::ADDR_NIBBLES - 1)) begin
          nxt_state = lpcpg_pkg::ST_SIZE;
        end
      end
      lpcpg_pkg::ST_SIZE: begin
        nxt_state = lpcpg_pkg::ST_DATA;
      end
      lpcpg_pkg::ST_DATA: begin
        if (early_end || (byte_push && count_at(byte_cnt_ff, lpcpg_pkg::PAGE_BYTES - 1))) begin
          nxt_state = lpcpg_pkg::ST_DRAIN;
        end
      end
      lpcpg_pkg::ST_DRAIN: begin
        if (!fifo_out_valid && !wr_busy && !commit_ff) begin
          nxt_state = lpcpg_pkg::ST_DONE;
        end
      end
      lpcpg_pkg::ST_DONE: begin
        nxt_state = lpcpg_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = lpcpg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= lpcpg_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // Address capture
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_cnt_ff <= '0;
    end else if (in_addr) begin
      addr_cnt_ff <= addr_cnt_ff + 1'b1;
    end else begin
      addr_cnt_ff <= '0;
    end
  end

  // One lane per address nibble; the first nibble sent lands in the top lane.
  for (genvar k = 0; k < lpcpg_pkg::ADDR_NIBBLES; k++) begin : g_addr_lane
    logic [3:0] nib_ff;
    logic       lane_hit;

    assign lane_hit    = in_addr && addr_cnt_ff == 3'(lpcpg_pkg::ADDR_NIBBLES - 1 - k);
    assign addr_nib[k] = nib_ff;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        nib_ff <= '0;
      end else if (lane_hit) begin
        nib_ff <= lad_in;
      end
    end
  end

  assign addr_word = addr_nib;

  // Only the page bits are kept; the byte offset bits are dropped.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      page_ff <= '0;
    end else if (state_ff == lpcpg_pkg::ST_SIZE) begin
      page_ff <= addr_word[lpcpg_pkg::PAGE_MSB:lpcpg_pkg::PAGE_LSB];
    end
  end

  // ----------------------------------------------------------------------
  // Nibble pairing and byte counter
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      half_ff     <= 1'b0;
      low_nib_ff  <= '0;
      byte_cnt_ff <= '0;
    end else if (state_ff != lpcpg_pkg::ST_DATA) begin
      half_ff     <= 1'b0;
      byte_cnt_ff <= '0;
    end else if (nib_take) begin
      half_ff <= !half_ff;
      if (!half_ff) begin
        low_nib_ff <= lad_in;
      end else begin
        byte_cnt_ff <= byte_cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Commit flag
  // ----------------------------------------------------------------------
  // The request is kept until the buffer has run empty, so a page that
  // still holds bytes at its end is programmed as well.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      commit_ff <= 1'b0;
    end else if (enter_drain) begin
      commit_ff <= 1'b1;
    end else if (commit_go) begin
      commit_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status and outputs
  // ----------------------------------------------------------------------
  // Busy while the buffer is full, and from the end of the page until the return to idle.
  assign nxt_ready = (fifo_in_ready || !in_data)
                     && nxt_state != lpcpg_pkg::ST_DRAIN && nxt_state != lpcpg_pkg::ST_DONE;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_ff <= 1'b1;
    end else begin
      ready_ff <= nxt_ready;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bypass_ff <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      bypass_ff <= supervoltage_in;
      done_ff   <= state_ff == lpcpg_pkg::ST_DONE;
    end
  end

  assign ready_busy_n_out = ready_ff;
  assign lock_bypass_out  = bypass_ff;
  assign page_done_out    = done_ff;
  assign write_valid_out  = wr_strobe;
  assign write_word_out   = wr_last;

  // ----------------------------------------------------------------------
  // Data buffer and array writer
  // ----------------------------------------------------------------------
  lpcpg_fifo #(
    .WIDTH ($bits(lpcpg_pkg::lpcpg_write_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (byte_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (wr_in_ready),
    .out_data_out  (fifo_word)
  );

  lpcpg_writer #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_writer (
    .sys_clk_in      (sys_clk_in),
    .rst_in          (rst_in),
    .in_valid_in     (fifo_out_valid),
    .in_ready_out    (wr_in_ready),
    .in_word_in      (fifo_word),
    .commit_in       (commit_go),
    .busy_out        (wr_busy),
    .last_word_out   (wr_last),
    .word_strobe_out (wr_strobe)
  );

endmodule : lpcpg_top

// ==== dv/lpcpg_host_model.sv ====
// Behavioural host that sends auto-increment page load frames.
`timescale 1ns/1ns
module lpcpg_host_model (
  input  wire logic  sys_clk_in,
  input  wire logic  ready_busy_n_in,
  output logic       frame_n_out,
  output logic [3:0] lad_out,
  output logic       load_strobe_n_out
);
  logic active;
  logic took;

  initial begin
    frame_n_out = 1'b1;
    lad_out = 4'h0;
    load_strobe_n_out = 1'b1;
    active = 1'b0;
    took = 1'b0;
  end

  // A nibble counts as taken when the strobe was low and ready was high.
  always @(posedge sys_clk_in) begin
    took <= ready_busy_n_in && !load_strobe_n_out;
  end

  // A released bus shows a pattern that changes every cycle.
  always @(negedge sys_clk_in) begin
    if (!active) begin
      lad_out <= ~lad_out;
    end
  end

  task automatic send(input logic [3:0] sel, input logic [27:0] addr, input int nb, input bit half,
                      input logic [7:0] base, input logic [3:0] size, input bit twice);
    logic [7:0] b;
    int n;
    // Claiming the bus before the edge keeps the idle pattern off the start code.
    active = 1'b1;
    @(negedge sys_clk_in);
    frame_n_out = 1'b0;
    lad_out = lpcpg_pkg::START_CODE;
    if (twice) begin
      @(negedge sys_clk_in);
    end
    @(negedge sys_clk_in);
    frame_n_out = 1'b1;
    lad_out = sel;
    for (n = 6; n >= 0; n--) begin
      @(negedge sys_clk_in);
      lad_out = addr[n*4 +: 4];
    end
    @(negedge sys_clk_in);
    lad_out = size;
    @(negedge sys_clk_in);
    for (n = 0; n < nb * 2 + int'(half); n++) begin
      b = base + 8'(n / 2) * 8'h03;
      load_strobe_n_out = 1'b0;
      lad_out = n[0] ? b[7:4] : b[3:0];
      @(negedge sys_clk_in);
      while (!took) begin
        @(negedge sys_clk_in);
      end
    end
    load_strobe_n_out = 1'b1;
    active = 1'b0;
  endtask : send
endmodule : lpcpg_host_model

// ==== dv/lpcpg_top_properties.sv ====
// Concurrent checks on the ports of the page load sequencer.
`timescale 1ns/1ns
module lpcpg_top_properties #(
  parameter int PROG_CYCLES = lpcpg_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH  = lpcpg_pkg::FIFO_DEPTH
) (
  input wire logic                       sys_clk_in,
  input wire logic                       rst_in,
  input wire logic                       frame_n_in,
  input wire logic [3:0]                 lad_in,
  input wire logic                       supervoltage_in,
  input wire logic                       load_strobe_n_in,
  input wire logic [3:0]                 strap_select_pins_in,
  input wire logic                       ready_busy_n_out,
  input wire logic                       lock_bypass_out,
  input wire logic                       write_valid_out,
  input wire lpcpg_pkg::lpcpg_write_type write_word_out,
  input wire logic                       page_done_out
);
  logic [7:0]                          idx_ff;
  logic [lpcpg_pkg::PAGE_ADDR_W-1:0]   page_ff;

  // Byte count and page of the command in progress.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_ff <= 8'h00;
      page_ff <= '0;
    end else if (page_done_out) begin
      idx_ff <= 8'h00;
    end else if (write_valid_out) begin
      idx_ff <= idx_ff + 8'h01;
      page_ff <= write_word_out.page;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_lock_follow;
    !$past(rst_in) |-> lock_bypass_out == $past(supervoltage_in);
  endproperty
  property p_index_order;
    write_valid_out |-> write_word_out.index == idx_ff[6:0];
  endproperty
  property p_byte_limit;
    write_valid_out |-> idx_ff < 8'h80;
  endproperty
  property p_page_fixed;
    write_valid_out && idx_ff != 8'h00 |-> write_word_out.page == page_ff;
  endproperty
  property p_done_after_busy;
    page_done_out |-> !$past(ready_busy_n_out);
  endproperty
  property p_ready_after_done;
    page_done_out |-> ##[0:2] ready_busy_n_out;
  endproperty
  property p_quiet_after_done;
    page_done_out |=> !write_valid_out [*8];
  endproperty
  property p_done_once;
    page_done_out |=> !page_done_out [*8];
  endproperty

  a_lock_follow: assert property (p_lock_follow) else $error("lock bypass differs from supervoltage");
  a_index_order: assert property (p_index_order) else $error("byte index out of order");
  a_byte_limit: assert property (p_byte_limit) else $error("more than a page of bytes written");
  a_page_fixed: assert property (p_page_fixed) else $error("page changed within a command");
  a_done_after_busy: assert property (p_done_after_busy) else $error("completion without busy");
  a_ready_after_done: assert property (p_ready_after_done) else $error("ready not back after completion");
  a_quiet_after_done: assert property (p_quiet_after_done) else $error("write after completion");
  a_done_once: assert property (p_done_once) else $error("second completion of one command");

  c_full_page: cover property (write_valid_out && write_word_out.index == 7'h7F);
  c_stall: cover property ($fell(ready_busy_n_out) && !load_strobe_n_in);
  c_done: cover property (page_done_out);
endmodule : lpcpg_top_properties

bind lpcpg_top lpcpg_top_properties #(.PROG_CYCLES(PROG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .frame_n_in(frame_n_in), .lad_in(lad_in),
  .supervoltage_in(supervoltage_in), .load_strobe_n_in(load_strobe_n_in),
  .strap_select_pins_in(strap_select_pins_in), .ready_busy_n_out(ready_busy_n_out),
  .lock_bypass_out(lock_bypass_out), .write_valid_out(write_valid_out),
  .write_word_out(write_word_out), .page_done_out(page_done_out)
);

// ==== dv/lpcpg_top_tb.sv ====
// Self-checking bench for the auto-increment page load sequencer.
`timescale 1ns/1ns
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", name, exp, got); end end
module lpcpg_top_tb;
  localparam int PROG = 20;
  logic                       clk;
  logic                       rst;
  logic                       sv;
  logic [3:0]                 strap;
  logic                       frame_n;
  logic [3:0]                 lad;
  logic                       ld_n;
  logic                       ready;
  logic                       lock;
  logic                       wv;
  lpcpg_pkg::lpcpg_write_type ww;
  logic                       pd;
  logic [13:0]                exp_page;
  logic [7:0]                 base;
  int                         seed;
  int                         wcnt;
  int                         dcnt;
  int                         bcnt;
  int                         n_errors;
  int                         num_checks;
  int                         i;
  int                         nb;

  lpcpg_top #(.PROG_CYCLES(PROG)) uut (
    .sys_clk_in(clk), .rst_in(rst), .frame_n_in(frame_n), .lad_in(lad), .supervoltage_in(sv),
    .load_strobe_n_in(ld_n), .strap_select_pins_in(strap), .ready_busy_n_out(ready),
    .lock_bypass_out(lock), .write_valid_out(wv), .write_word_out(ww), .page_done_out(pd)
  );
  lpcpg_host_model host (
    .sys_clk_in(clk), .ready_busy_n_in(ready), .frame_n_out(frame_n), .lad_out(lad),
    .load_strobe_n_out(ld_n)
  );

  function automatic lpcpg_pkg::lpcpg_write_type exp_word(input int idx);
    lpcpg_pkg::lpcpg_write_type w;
    w.page = exp_page;
    w.index = 7'(idx);
    w.data = base + 8'(idx) * 8'h03;
    return w;
  endfunction : exp_word

  // Every byte written must be the next byte of the addressed page.
  always @(negedge clk) begin
    if (wv === 1'b1) begin
      `CHK("write_word", exp_word(wcnt), ww)
      wcnt++;
    end
    if (pd === 1'b1) begin
      dcnt++;
    end
    if (ready === 1'b0) begin
      bcnt++;
    end
  end

  task automatic run(input string name, input logic sv_v, input bit sel_ok, input int n, input bit half,
                     input bit twice, input int exp_n, input int exp_d);
    logic [27:0] a;
    int k;
    a = 28'($random(seed));
    strap = 4'($random(seed));
    base = 8'($random(seed));
    exp_page = a[20:7];
    wcnt = 0;
    dcnt = 0;
    bcnt = 0;
    sv = sv_v;
    @(negedge clk);
    @(negedge clk);
    `CHK("lock_bypass", sv_v, lock)
    host.send(sel_ok ? strap : ~strap, a, n, half, base, 4'($random(seed)), twice);
    for (k = 0; k < 600 && dcnt < exp_d; k++) begin
      @(negedge clk);
    end
    repeat (20) @(negedge clk);
    `CHK("bytes_written", exp_n, wcnt)
    `CHK("completions", exp_d, dcnt)
    `CHK("programming_busy", exp_d == 1, bcnt >= PROG)
    `CHK("ready_idle", 1'b1, ready)
    sv = 1'b0;
    $display("test %s finished", name);
  endtask : run

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    seed = 32'h5522DF32;
    n_errors = 0;
    num_checks = 0;
    rst = 1'b1;
    sv = 1'b0;
    strap = 4'h0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    run("full_page_double_start", 1'b1, 1'b1, 128, 1'b0, 1'b1, 128, 1);
    run("partial_with_half_byte", 1'b1, 1'b1, 37, 1'b1, 1'b0, 37, 1);
    run("empty_page", 1'b1, 1'b1, 0, 1'b0, 1'b0, 0, 1);
    run("select_mismatch", 1'b1, 1'b0, 5, 1'b0, 1'b0, 0, 0);
    run("no_supervoltage", 1'b0, 1'b1, 5, 1'b0, 1'b0, 0, 0);
    for (i = 0; i < 4; i++) begin
      nb = 1 + int'({$random(seed)} % 128);
      run("random_page", 1'b1, 1'b1, nb, 1'($random(seed)), 1'b0, nb, 1);
    end
    end_of_test();
  end
endmodule : lpcpg_top_tb
